/* File: rtl/fpc_pkg.sv */
package fpc_pkg;

  localparam int CLK_PS = 8000; // MCLK period in ps
  localparam int T_ACC_NS = 100; // Read access allowance
  localparam int T_WP_NS = 50; // Write strobe low time
  localparam int T_PD_LOW_NS = 100; // Reset pulse low time
  localparam int T_WAKE_NS = 1000; // Wake time after reset release
  localparam int SYNC_STAGES = 2; // Input synchroniser depth

  // Least time rounded up to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] RD_CYC = 8'(ns2cyc(T_ACC_NS) + SYNC_STAGES);
  localparam logic [7:0] WP_CYC = 8'(ns2cyc(T_WP_NS));
  localparam logic [7:0] PD_LOW_CYC = 8'(ns2cyc(T_PD_LOW_NS));
  localparam logic [7:0] REC_CYC = 8'(ns2cyc(T_WAKE_NS));

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int TOP_BIT = 15;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_RECOVER,
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD
  } fpc_state_e;

  typedef struct packed {
    fpc_state_e state;
    logic [7:0] cnt;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_n;
    logic unlock_hv;
    logic wp;
    logic byte_n;
    logic vpp_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_lo;
    logic dq_oe_mid;
    logic dq_oe_top;
    logic [DATA_W-1:0] rdata;
    logic rsp_valid;
    logic ready;
  } fpc_state_s;

  localparam fpc_state_s ST_RST_VAL = '{
    state: ST_RESET, cnt: 8'h00, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0,
    unlock_hv: 1'b0, wp: 1'b0, byte_n: 1'b1, vpp_en: 1'b0, addr: '0, dq_o: '0,
    dq_oe_lo: 1'b0, dq_oe_mid: 1'b0, dq_oe_top: 1'b0, rdata: '0, rsp_valid: 1'b0,
    ready: 1'b0};

endpackage

/* File: rtl/fpc_sync.sv */
`timescale 1ns/1ps
module fpc_sync (
  input wire logic MCLK, // Clock
  input wire logic RST, // Async reset, high
  input wire logic [fpc_pkg::DATA_W-1:0] d, // Pin levels
  output logic [fpc_pkg::DATA_W-1:0] q // Synchronised levels
);

  typedef struct packed {
    logic [fpc_pkg::DATA_W-1:0] meta;
    logic [fpc_pkg::DATA_W-1:0] stab;
  } fpc_sync_s;

  fpc_sync_s s_r;
  fpc_sync_s s_nxt;

  // Second stage reads only the first
  always_comb
  begin
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end

  // Two flops against metastability on the data pins
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.stab;

endmodule

/* File: rtl/fpc_host.sv */
`timescale 1ns/1ps
module fpc_host (
  input wire logic MCLK, // 125 MHz clock
  input wire logic RST, // Async reset, high
  input wire logic REQ_VALID, // Access request
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic REQ_BYTE, // 1 byte mode access
  input wire logic [18:0] REQ_ADDR, // Byte or word address
  input wire logic [15:0] REQ_WDATA, // Write data or command
  input wire logic RST_REQ, // Pulse device reset
  input wire logic HV_UNLOCK, // Request unlock level on reset pin
  input wire logic BOOT_UNLOCK, // Lock release level
  input wire logic VPP_ON, // Program supply request
  output logic REQ_READY, // Idle, request taken
  output logic RSP_VALID, // Read data pulse
  output logic [15:0] RSP_RDATA, // Read data
  output logic FL_CS_N, // Chip select
  output logic FL_OE_N, // Output enable
  output logic FL_WE_N, // Write strobe
  output logic FL_RESET_POWERDOWN_N, // Reset and power-down
  output logic FL_UNLOCK_HV, // Switch reset pin to high unlock level
  output logic FL_WP, // Boot lock release
  output logic FL_BYTE_N, // Width select
  output logic FL_VPP_EN, // Program supply switch
  output logic [17:0] FL_ADDR, // Address bus
  output logic [15:0] FL_DQ_O, // Data out
  output logic FL_DQ_OE_LO, // Drive DQ7..0
  output logic FL_DQ_OE_MID, // Drive DQ14..8
  output logic FL_DQ_OE_TOP, // Drive DQ15 or address LSB
  input wire logic [15:0] FL_DQ_I // Data in from pins
);

  localparam int RD_LAT = 20; // Bound on read answer
  localparam int RST_LAT = 160; // Bound on reset sequence

  fpc_pkg::fpc_state_s s_r;
  fpc_pkg::fpc_state_s s_nxt;
  logic [15:0] dq_s;

  fpc_sync u_sync (
    .MCLK(MCLK),
    .RST(RST),
    .d(FL_DQ_I),
    .q(dq_s)
  );

  // Sequencer for reset, read and write cycles
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.wp = BOOT_UNLOCK;
    s_nxt.vpp_en = VPP_ON; // User holds it until completion
    unique case (s_r.state)
      fpc_pkg::ST_RESET:
      begin
        s_nxt.reset_powerdown_n = 1'b0;
        s_nxt.unlock_hv = 1'b0;
        if (s_r.cnt >= fpc_pkg::PD_LOW_CYC - 8'h01)
        begin
          s_nxt.state = fpc_pkg::ST_RECOVER;
          s_nxt.reset_powerdown_n = 1'b1;
          s_nxt.cnt = 8'h00;
        end
        else
          s_nxt.cnt = s_r.cnt + 8'h01;
      end
      fpc_pkg::ST_RECOVER:
      begin
        // Device wakes in array read with clear status
        if (s_r.cnt >= fpc_pkg::REC_CYC - 8'h01)
        begin
          s_nxt.state = fpc_pkg::ST_IDLE;
          s_nxt.cnt = 8'h00;
        end
        else
          s_nxt.cnt = s_r.cnt + 8'h01;
      end
      fpc_pkg::ST_IDLE:
      begin
        s_nxt.cs_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.we_n = 1'b1;
        s_nxt.dq_oe_lo = 1'b0;
        s_nxt.dq_oe_mid = 1'b0;
        s_nxt.dq_oe_top = 1'b0;
        s_nxt.unlock_hv = HV_UNLOCK; // Only unlock leaves plain high
        s_nxt.cnt = 8'h00;
        if (RST_REQ)
        begin
          s_nxt.state = fpc_pkg::ST_RESET;
          s_nxt.reset_powerdown_n = 1'b0;
          s_nxt.unlock_hv = 1'b0;
        end
        else if (REQ_VALID)
        begin
          s_nxt.cs_n = 1'b0;
          s_nxt.byte_n = ~REQ_BYTE;
          // Byte mode: upper address bits on bus, LSB on top data pin
          s_nxt.addr = REQ_BYTE ? REQ_ADDR[18:1] : REQ_ADDR[17:0];
          s_nxt.dq_o = REQ_WDATA;
          s_nxt.dq_o[fpc_pkg::TOP_BIT] = REQ_BYTE ? REQ_ADDR[0] : REQ_WDATA[fpc_pkg::TOP_BIT];
          s_nxt.dq_oe_top = REQ_BYTE | REQ_WRITE;
          if (REQ_WRITE)
          begin
            s_nxt.state = fpc_pkg::ST_WR_SETUP;
            s_nxt.dq_oe_lo = 1'b1;
            s_nxt.dq_oe_mid = ~REQ_BYTE;
          end
          else
          begin
            // Read: bus released before output enable falls
            s_nxt.state = fpc_pkg::ST_RD_WAIT;
            s_nxt.oe_n = 1'b0;
          end
        end
      end
      fpc_pkg::ST_RD_WAIT:
      begin
        if (s_r.cnt >= fpc_pkg::RD_CYC - 8'h01)
        begin
          // Byte mode reads only the low lines
          s_nxt.rdata = s_r.byte_n ? dq_s : {8'h00, dq_s[7:0]};
          s_nxt.rsp_valid = 1'b1;
          s_nxt.state = fpc_pkg::ST_IDLE;
          s_nxt.cs_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.dq_oe_top = 1'b0;
        end
        else
          s_nxt.cnt = s_r.cnt + 8'h01;
      end
      fpc_pkg::ST_WR_SETUP:
      begin
        s_nxt.state = fpc_pkg::ST_WR_PULSE;
        s_nxt.we_n = 1'b0;
      end
      fpc_pkg::ST_WR_PULSE:
      begin
        if (s_r.cnt >= fpc_pkg::WP_CYC - 8'h01)
        begin
          s_nxt.state = fpc_pkg::ST_WR_HOLD;
          s_nxt.we_n = 1'b1;
          s_nxt.cnt = 8'h00;
        end
        else
          s_nxt.cnt = s_r.cnt + 8'h01;
      end
      fpc_pkg::ST_WR_HOLD:
      begin
        // Data held one cycle past the rising strobe
        s_nxt.state = fpc_pkg::ST_IDLE;
        s_nxt.cs_n = 1'b1;
        s_nxt.dq_oe_lo = 1'b0;
        s_nxt.dq_oe_mid = 1'b0;
        s_nxt.dq_oe_top = 1'b0;
      end
      default:
        s_nxt.state = fpc_pkg::ST_RESET;
    endcase
    s_nxt.ready = (s_nxt.state == fpc_pkg::ST_IDLE) && !(s_r.state == fpc_pkg::ST_IDLE && REQ_VALID);
  end

  // Reset also pulses the device reset pin
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      s_r <= fpc_pkg::ST_RST_VAL;
    else
      s_r <= s_nxt;
  end

  // All outputs straight from the state register
  assign REQ_READY = s_r.ready;
  assign RSP_VALID = s_r.rsp_valid;
  assign RSP_RDATA = s_r.rdata;
  assign FL_CS_N = s_r.cs_n;
  assign FL_OE_N = s_r.oe_n;
  assign FL_WE_N = s_r.we_n;
  assign FL_RESET_POWERDOWN_N = s_r.reset_powerdown_n;
  assign FL_UNLOCK_HV = s_r.unlock_hv;
  assign FL_WP = s_r.wp;
  assign FL_BYTE_N = s_r.byte_n;
  assign FL_VPP_EN = s_r.vpp_en;
  assign FL_ADDR = s_r.addr;
  assign FL_DQ_O = s_r.dq_o;
  assign FL_DQ_OE_LO = s_r.dq_oe_lo;
  assign FL_DQ_OE_MID = s_r.dq_oe_mid;
  assign FL_DQ_OE_TOP = s_r.dq_oe_top;

  // Pin protocol checks, silent while the block itself is in reset
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  reset_plain_high_a: assert property (!FL_RESET_POWERDOWN_N |->
    s_r.state == fpc_pkg::ST_RESET && !FL_UNLOCK_HV)
    else $error("reset pin low outside reset");
  no_contention_a: assert property (!FL_OE_N |-> !FL_DQ_OE_LO && !FL_DQ_OE_MID && FL_WE_N)
    else $error("host drives data while device outputs on");
  byte_float_a: assert property (!FL_BYTE_N |-> !FL_DQ_OE_MID)
    else $error("mid data lines driven in byte mode");
  byte_lsb_a: assert property (!FL_BYTE_N && !FL_CS_N && !FL_OE_N |-> FL_DQ_OE_TOP)
    else $error("address LSB not driven in byte read");
  write_strobe_a: assert property (!FL_WE_N |->
    FL_OE_N && !FL_CS_N && FL_DQ_OE_LO && FL_RESET_POWERDOWN_N)
    else $error("write strobe outside a proper write");
  wr_data_stable_a: assert property (!FL_WE_N |-> $stable(FL_DQ_O) && $stable(FL_ADDR))
    else $error("write data or address moved under strobe");
  strobe_width_a: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*7] ##1 FL_WE_N)
    else $error("write strobe width wrong");
  read_answer_a: assert property (REQ_READY && REQ_VALID && !REQ_WRITE && !RST_REQ |-> ##[1:RD_LAT] RSP_VALID)
    else $error("read answer late");
  wake_wait_a: assert property ($rose(FL_RESET_POWERDOWN_N) |-> !REQ_READY [*8])
    else $error("request accepted before device woke");
  reset_done_a: assert property (REQ_READY && RST_REQ |-> ##[1:RST_LAT] REQ_READY)
    else $error("reset sequence too long");

  // Main scenarios reached
  read_word_c: cover property (RSP_VALID && FL_BYTE_N);
  read_byte_c: cover property (RSP_VALID && !FL_BYTE_N);
  write_c: cover property ($rose(FL_WE_N) && FL_VPP_EN);
  write_byte_c: cover property ($rose(FL_WE_N) && !FL_BYTE_N);
  reset_c: cover property ($rose(FL_RESET_POWERDOWN_N));

endmodule

/* File: testbench/fpc_flash_model.sv */
`timescale 1ns/1ps
module fpc_flash_model (
  input wire logic cs_n, // Chip select
  input wire logic oe_n, // Output enable
  input wire logic we_n, // Write strobe
  input wire logic reset_powerdown_n, // Reset, power-down
  input wire logic byte_n, // Width select
  input wire logic [17:0] addr, // Address
  input wire logic [15:0] dq, // Resolved pins
  output logic [15:0] q, // Read data
  output logic oe_lo, // Drives DQ7..0
  output logic oe_hi // Drives DQ15..8
);
  logic [7:0] mem [0:511];
  logic [8:0] ix;
  // Small array, so high address bits alias
  assign ix = {addr[7:0], byte_n ? 1'b0 : dq[15]};
  // Only array read exists, so reset has no mode to restore
  assign oe_lo = reset_powerdown_n & ~cs_n & ~oe_n & we_n;
  assign oe_hi = oe_lo & byte_n;
  assign q = {mem[ix | 9'h001], mem[ix]};
  // Data taken as the strobe rises, ignored in power-down
  always @(posedge we_n)
    if (reset_powerdown_n && !cs_n)
    begin
      mem[ix] <= dq[7:0];
      if (byte_n)
        mem[ix | 9'h001] <= dq[15:8];
    end
endmodule

/* File: testbench/test_fpc_host.sv */
`timescale 1ns/1ps
module test_fpc_host;
  logic MCLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_BYTE = 1'b0;
  logic RST_REQ = 1'b0, BOOT_UNLOCK = 1'b0;
  logic HV_UNLOCK = 1'b0; // Low outside the supply test
  logic VPP_ON = 1'b1; // Held valid through every write
  logic [18:0] REQ_ADDR = '0;
  logic [15:0] REQ_WDATA = '0, RSP_RDATA, FL_DQ_O, d_q;
  wire [15:0] pins; // Resolved data pins
  logic [15:0] flt = 16'ha5a5;
  logic [17:0] FL_ADDR;
  logic REQ_READY, RSP_VALID, FL_CS_N, FL_OE_N, FL_WE_N, FL_RESET_POWERDOWN_N, FL_UNLOCK_HV, FL_WP, FL_BYTE_N;
  logic FL_VPP_EN, FL_DQ_OE_LO, FL_DQ_OE_MID, FL_DQ_OE_TOP, d_lo, d_hi;
  logic [7:0] sh [0:511];
  logic [15:0] exp_q [$];
  logic [18:0] wa [0:5];
  logic [15:0] r = 16'h3b23;
  int failures = 0, cmp_count = 0, n;
  fpc_host dut_u (.MCLK(MCLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_BYTE(REQ_BYTE),
    .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RST_REQ(RST_REQ), .HV_UNLOCK(HV_UNLOCK),
    .BOOT_UNLOCK(BOOT_UNLOCK), .VPP_ON(VPP_ON), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .FL_CS_N(FL_CS_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
    .FL_RESET_POWERDOWN_N(FL_RESET_POWERDOWN_N), .FL_UNLOCK_HV(FL_UNLOCK_HV), .FL_WP(FL_WP),
    .FL_BYTE_N(FL_BYTE_N), .FL_VPP_EN(FL_VPP_EN), .FL_ADDR(FL_ADDR),
    .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_LO(FL_DQ_OE_LO), .FL_DQ_OE_MID(FL_DQ_OE_MID),
    .FL_DQ_OE_TOP(FL_DQ_OE_TOP), .FL_DQ_I(pins));
  fpc_flash_model model_u (.cs_n(FL_CS_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
    .reset_powerdown_n(FL_RESET_POWERDOWN_N), .byte_n(FL_BYTE_N), .addr(FL_ADDR), .dq(pins), .q(d_q),
    .oe_lo(d_lo), .oe_hi(d_hi));
  // Undriven lines toggle, so a float never reads as valid data
  assign pins[7:0] = FL_DQ_OE_LO ? FL_DQ_O[7:0] : d_lo ? d_q[7:0] : flt[7:0];
  assign pins[14:8] = FL_DQ_OE_MID ? FL_DQ_O[14:8] : d_hi ? d_q[14:8] : flt[14:8];
  assign pins[15] = FL_DQ_OE_TOP ? FL_DQ_O[15] : d_hi ? d_q[15] : flt[15];
  initial
  begin
    forever #4 MCLK = ~MCLK;
  end
  always @(posedge MCLK)
    flt <= ~flt;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do
    begin
      @(negedge MCLK);
      k++;
    end
    while (REQ_READY !== 1'b1 && k < 400);
    if (REQ_READY !== 1'b1)
    begin
      chk("ready", 16'h1, 16'h0);
      report_and_stop();
    end
  endtask
  // One request; the shadow array gives the expected read
  task automatic acc(input logic w, input logic b, input logic [18:0] a, input logic [15:0] d);
    logic [8:0] i;
    i = b ? a[8:0] : {a[7:0], 1'b0};
    wait_rdy();
    @(posedge MCLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= w;
    REQ_BYTE <= b;
    REQ_ADDR <= a;
    REQ_WDATA <= d;
    if (w)
    begin
      sh[i] = d[7:0];
      if (!b)
        sh[i | 9'h001] = d[15:8];
    end
    else
      exp_q.push_back(b ? {8'h00, sh[i]} : {sh[i | 9'h001], sh[i]});
    @(posedge MCLK);
    REQ_VALID <= 1'b0;
  endtask
  // Read results and pin ownership checked every cycle
  always @(negedge MCLK)
    if (!RST)
    begin
      if (RSP_VALID === 1'b1)
        chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 16'hdead, RSP_RDATA);
      chk("pin_own", 16'h0, {12'h0, (FL_DQ_OE_MID | FL_DQ_OE_TOP) & d_hi, FL_DQ_OE_LO & d_lo,
        ~FL_BYTE_N & FL_DQ_OE_MID,
        ~FL_RESET_POWERDOWN_N & (FL_DQ_OE_LO | FL_DQ_OE_TOP)});
    end
  initial
  begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      r = lfsr(r);
      wa[k] = (k == 0) ? 19'h3ffff : {3'h0, r};
      r = lfsr(r);
      acc(1'b1, 1'b0, wa[k], r);
    end
    for (int k = 0; k < 6; k++)
      acc(1'b0, 1'b0, wa[k], 16'h0);
    $display("word test done");
    for (int k = 0; k < 4; k++)
    begin
      r = lfsr(r);
      acc(1'b1, 1'b1, {wa[k][17:0], r[0]}, r);
      acc(1'b0, 1'b1, {wa[k][17:0], 1'b0}, 16'h0);
      acc(1'b0, 1'b1, {wa[k][17:0], 1'b1}, 16'h0);
      acc(1'b0, 1'b0, wa[k], 16'h0);
    end
    $display("byte test done");
    wait_rdy();
    @(posedge MCLK);
    RST_REQ <= 1'b1;
    @(posedge MCLK);
    RST_REQ <= 1'b0;
    n = 0;
    repeat (300) @(negedge MCLK) n += (FL_RESET_POWERDOWN_N === 1'b0);
    chk("pd_low", {8'h00, fpc_pkg::PD_LOW_CYC}, 16'(n));
    for (int k = 0; k < 4; k++)
      acc(1'b0, 1'b0, wa[k], 16'h0);
    $display("reset test done");
    for (int k = 0; k < 8; k++)
    begin
      r = lfsr(r);
      wait_rdy();
      @(posedge MCLK);
      {HV_UNLOCK, VPP_ON, BOOT_UNLOCK} <= r[2:0];
      repeat (2) @(negedge MCLK);
      chk("supply", {13'h0, r[2:0]}, {13'h0, FL_UNLOCK_HV, FL_VPP_EN, FL_WP});
    end
    $display("supply test done");
    chk("pending", 16'h0, 16'(exp_q.size()));
    report_and_stop();
  end
endmodule
